// ### acrc_checker.sv
// Port-level checker for the converter clock and rate control block.
// Assumes one pclk domain; bound onto acrc_top from the testbench file.
`timescale 1ns/100ps
module acrc_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        cs_n,
	input wire logic        sclk,
	input wire logic        dout,
	input wire logic        dout_oe_n,
	input wire logic        sample_strobe,
	input wire logic        external_clock_select,
	input wire logic        line_frequency_select,
	input wire logic        signal_buffer_enable,
	input wire logic        unipolar_select,
	input wire logic        single_cycle_select,
	input wire logic        irq
);
	// Single domain, everything off in reset
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Access phase still waiting for its answer
	sequence apb_wait;
		psel && penable && !pready;
	endsequence
	// Select held long enough to pass the synchroniser
	sequence cs_quiet;
		cs_n [*5];
	endsequence
	sequence cs_busy;
		!cs_n [*5];
	endsequence

	// Exactly one wait state per access
	ready_wait_a: assert property (apb_wait |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	// Error only for places past the last register
	err_unmapped_a: assert property (pready |-> pslverr == (paddr > acrc_pkg::REG_CONV))
		else $error("pslverr wrong for address");
	// Completing write to the control register
	sequence ctrl_wr;
		pready && pwrite && !pslverr && paddr == acrc_pkg::REG_CTRL;
	endsequence
	// Configuration outputs follow a control write
	ctrl_write_a: assert property (ctrl_wr |->
		{single_cycle_select, unipolar_select, signal_buffer_enable,
		line_frequency_select, external_clock_select} == pwdata[4:0])
		else $error("selects differ from written control");
	dout_fall_a: assert property (!dout_oe_n && $past(!dout_oe_n) && $changed(dout)
		|-> !sclk && $past(!sclk))
		else $error("data out moved outside a low clock phase");
	oe_release_a: assert property (cs_quiet |-> dout_oe_n)
		else $error("data out driven while deselected");
	oe_drive_a: assert property (cs_busy |-> !dout_oe_n)
		else $error("data out not driven while selected");
	// Ten system ticks per sample, so strobes stay well apart
	strobe_gap_a: assert property (sample_strobe |=> !sample_strobe [*8])
		else $error("sample strobes too close");
	irq_mask_a: assert property (pready && pwrite && paddr == acrc_pkg::REG_MASK
		&& pwdata[2:0] == 3'h0 |=> !irq)
		else $error("irq high with all sources masked");
endmodule

// ### acrc_host_model.sv
// Serial host model: select, serial clock and data toward the device.
// Assumes the device samples on clock rise and shifts out on fall.
`timescale 1ns/100ps
module acrc_host_model (
	output logic      cs_n,
	output logic      sclk,
	output logic      din,
	input  wire logic dout,
	input  wire logic dout_oe_n
);
	// Idle: deselected, clock parked high between frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din  = 1'b0;
	end

	// One frame, n bits MSB first, 1 MHz clock
	task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx   = 32'h0000_0000;
		cs_n = 1'b0;
		#1030;
		for (int i = n - 1; i >= 0; i--) begin
			sclk = 1'b0;
			din  = tx[i];
			#500;
			sclk = 1'b1;
			// Released line reads as garbage, never as last value
			rx   = {rx[30:0], dout_oe_n ? ~rx[0] : dout};
			#500;
		end
		cs_n = 1'b1;
		din  = ~din; // No stale data once deselected
		#2000;
	endtask
endmodule

// ### acrc_pkg.sv
// Package for the converter clock and rate control block.
// Assumes a 10 MHz APB clock and a 12-bit byte address on the bus.
package acrc_pkg;

	// Bus clock, in hertz
	localparam longint unsigned PCLK_HZ = 64'd10_000_000;
	// Internal oscillator figures, in hertz (2.4576MHz and 2.048MHz)
	localparam longint unsigned OSC_HI_HZ = 64'd2_457_600;
	localparam longint unsigned OSC_LO_HZ = 64'd2_048_000;
	// Phase accumulator width and its per-pclk increments
	localparam int unsigned NCO_W = 24;
	localparam logic [23:0] NCO_INC_HI = 24'((OSC_HI_HZ * (64'd1 << NCO_W)) / PCLK_HZ);
	localparam logic [23:0] NCO_INC_LO = 24'((OSC_LO_HZ * (64'd1 << NCO_W)) / PCLK_HZ);
	// Input sampling is the system clock divided by ten
	localparam logic [3:0] SAMPLE_DIV_LAST = 4'h9;

	// Samples per conversion, continuous mode, codes 100..111
	localparam logic [17:0] CONT_SAMPLES_4 = 18'h01000;
	localparam logic [17:0] CONT_SAMPLES_5 = 18'h00800;
	localparam logic [17:0] CONT_SAMPLES_6 = 18'h00400;
	localparam logic [17:0] CONT_SAMPLES_7 = 18'h00200;
	// Samples per conversion, single-cycle mode, codes 000..111
	localparam logic [17:0] SCYC_SAMPLES_0 = 18'h3c000;
	localparam logic [17:0] SCYC_SAMPLES_1 = 18'h18000;
	localparam logic [17:0] SCYC_SAMPLES_2 = 18'h0c000;
	localparam logic [17:0] SCYC_SAMPLES_3 = 18'h06000;
	localparam logic [17:0] SCYC_SAMPLES_4 = 18'h04000;
	localparam logic [17:0] SCYC_SAMPLES_5 = 18'h02000;
	localparam logic [17:0] SCYC_SAMPLES_6 = 18'h01000;
	localparam logic [17:0] SCYC_SAMPLES_7 = 18'h00800;

	// Register byte offsets
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_GPIO   = 12'h004;
	localparam logic [11:0] REG_DATA   = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00c;
	localparam logic [11:0] REG_MASK   = 12'h010;
	localparam logic [11:0] REG_CONV   = 12'h014;

	// Configuration field positions (all but the rate same in the serial byte)
	localparam int unsigned CTRL_EXT_BIT  = 0;
	localparam int unsigned CTRL_LINE_BIT = 1;
	localparam int unsigned CTRL_BUF_BIT  = 2;
	localparam int unsigned CTRL_UNI_BIT  = 3;
	localparam int unsigned CTRL_SCYC_BIT = 4;
	localparam int unsigned CTRL_RATE_LSB = 8;
	// Reset values
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [2:0] RATE_RESET = 3'h4;
	localparam logic [3:0] GPIO_OE_N_RESET = 4'hf;

	// Status bits
	localparam int unsigned ST_DONE_BIT    = 0;
	localparam int unsigned ST_FRAME_BIT   = 1;
	localparam int unsigned ST_OVERRUN_BIT = 2;

	// Serial command byte fields
	localparam int unsigned CMD_CONV_BIT = 7;
	localparam logic [1:0]  CMD_READ     = 2'h3;
	localparam int unsigned CMD_GPIO_BIT = 6;
	// Last bit index of each serial phase
	localparam logic [4:0] SER_BYTE_LAST = 5'h07;
	localparam logic [4:0] SER_READ_LAST = 5'h17;

	// Serial engine states, Gray coded in the order command, write, read, done
	typedef enum logic [1:0] {
		ACRC_SER_CMD   = 2'b00,
		ACRC_SER_WRITE = 2'b01,
		ACRC_SER_READ  = 2'b11,
		ACRC_SER_DONE  = 2'b10
	} acrc_ser_state_t;

endpackage

// ### acrc_top.sv
// Converter clock and rate control: APB registers, serial pins,
// clock source, sampling divider and conversion timing.
// Assumes pins arrive asynchronously to pclk and conv_data is pclk-synchronous.
//
// Functional notes
// - Sample serial input on serial clock rise
// - Change data-out only on serial clock fall
// - Data-out low signals result ready
// - External clock setting runs from clock pin
// - Other clock rates scale timing proportionally
// - Line setting picks 2.4576 or 2.048 MHz
// - System clock divided down for timing
// - Sampling runs at system clock over ten
// - Buffer bit enables analog input buffer
// - Polarity bit picks bipolar or unipolar
// - Continuous codes 100-111 give four rates
// - Single-cycle rates at line setting zero
// - Single-cycle rates at line setting one
// - Four general pins under serial control
// - 2.4576 MHz places sixty hertz rejection
// - Mode bit: zero continuous, one single-cycle
// - 2.048 MHz places fifty hertz rejection
`timescale 1ns/100ps

module acrc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        din,
	output logic             dout,
	output logic             dout_oe_n,
	input  wire logic        ext_clk,
	input  wire logic        general_pin_one_in,
	input  wire logic        general_pin_two_in,
	input  wire logic        general_pin_three_in,
	input  wire logic        general_pin_four_in,
	output logic             general_pin_one_out,
	output logic             general_pin_two_out,
	output logic             general_pin_three_out,
	output logic             general_pin_four_out,
	output logic             general_pin_one_oe_n,
	output logic             general_pin_two_oe_n,
	output logic             general_pin_three_oe_n,
	output logic             general_pin_four_oe_n,
	input  wire logic [23:0] conv_data,
	output logic             sample_strobe,
	output logic             external_clock_select,
	output logic             line_frequency_select,
	output logic             signal_buffer_enable,
	output logic             unipolar_select,
	output logic             single_cycle_select,
	output logic             irq
);

	// Whole state of the block
	typedef struct packed {
		logic [2:0]                cs_s;       // Chip select sync, [2] is history
		logic [2:0]                sclk_s;     // Serial clock sync, [2] is history
		logic [1:0]                din_s;      // Serial data sync
		logic [2:0]                ext_s;      // External clock sync, [2] is history
		logic [3:0]                gin_a;      // Pin input, first stage
		logic [3:0]                gin_b;      // Pin input, second stage
		logic [31:0]               prdata;     // Read data
		logic                      pready;     // Access done
		logic                      pslverr;    // Unmapped address
		logic [4:0]                ctrl;       // Clock and analog configuration
		logic [2:0]                rate;       // Rate code
		logic [3:0]                gout;       // Pin output values
		logic [3:0]                goe_n;      // Pin drive enables, low drives
		logic [2:0]                status;     // Sticky events
		logic [2:0]                mask;       // Interrupt enables
		logic                      irq;        // Interrupt level
		acrc_pkg::acrc_ser_state_t ser_state;  // Serial phase
		logic [4:0]                bit_cnt;    // Bits taken in this phase
		logic [7:0]                sin;        // Serial input shifter
		logic [23:0]               sout;       // Serial output shifter
		logic                      wr_gpio;    // Serial write target
		logic                      dout;       // Data-out pin level
		logic                      dout_oe_n;  // Data-out drive enable
		logic [23:0]               phase;      // Oscillator accumulator
		logic [3:0]                div;        // Sampling divider
		logic                      strobe;     // Sample pulse
		logic                      run;        // Conversion in progress
		logic [17:0]               samples;    // Samples in this conversion
		logic [23:0]               result;     // Last result
		logic                      ready;      // Result not yet read
	} acrc_state_t;

	acrc_state_t q;      // Registered state
	acrc_state_t next_q; // Next state

	// Samples per conversion for a mode and rate code
	function automatic logic [17:0] conv_samples(input logic scyc, input logic [2:0] code);
		logic [17:0] n;
		n = acrc_pkg::CONT_SAMPLES_4;
		if (scyc) begin
			case (code)
				3'h0:    n = acrc_pkg::SCYC_SAMPLES_0;
				3'h1:    n = acrc_pkg::SCYC_SAMPLES_1;
				3'h2:    n = acrc_pkg::SCYC_SAMPLES_2;
				3'h3:    n = acrc_pkg::SCYC_SAMPLES_3;
				3'h4:    n = acrc_pkg::SCYC_SAMPLES_4;
				3'h5:    n = acrc_pkg::SCYC_SAMPLES_5;
				3'h6:    n = acrc_pkg::SCYC_SAMPLES_6;
				default: n = acrc_pkg::SCYC_SAMPLES_7;
			endcase
		end else begin
			// Undefined low codes fall back to the slowest defined rate
			case (code)
				3'h5:    n = acrc_pkg::CONT_SAMPLES_5;
				3'h6:    n = acrc_pkg::CONT_SAMPLES_6;
				3'h7:    n = acrc_pkg::CONT_SAMPLES_7;
				default: n = acrc_pkg::CONT_SAMPLES_4;
			endcase
		end
		return n;
	endfunction

	// Status set bits
	logic [2:0]  st_set;
	// Status clear bits from a one written
	logic [2:0]  st_clr;
	// Edge and select decodes
	logic        sel;
	logic        frame_end;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        sys_tick;
	logic        sample_tick;
	logic        start;
	logic [2:0]  start_rate;
	logic [7:0]  rx_byte;
	logic [24:0] nco_sum;
	logic        access;

	// Next-state logic for every register of the block
	always_comb begin
		next_q = q;
		st_set = 3'h0;
		st_clr = 3'h0;
		start = 1'b0;
		start_rate = q.rate;
		rx_byte = {q.sin[6:0], q.din_s[1]};
		nco_sum = 25'h0;

		// Two-flop synchronisers; only stage two and history are read
		next_q.cs_s = {q.cs_s[1], q.cs_s[0], cs_n};
		next_q.sclk_s = {q.sclk_s[1], q.sclk_s[0], sclk};
		next_q.din_s = {q.din_s[0], din};
		next_q.ext_s = {q.ext_s[1], q.ext_s[0], ext_clk};
		next_q.gin_a = {general_pin_four_in, general_pin_three_in,
			general_pin_two_in, general_pin_one_in};
		next_q.gin_b = q.gin_a;

		sel = ~q.cs_s[1];
		frame_end = q.cs_s[1] & ~q.cs_s[2];
		sclk_rise = q.sclk_s[1] & ~q.sclk_s[2];
		sclk_fall = ~q.sclk_s[1] & q.sclk_s[2];

		// APB access: answer one cycle into the access phase
		access = psel & penable & ~q.pready;
		next_q.pready = access;
		next_q.pslverr = 1'b0;
		if (access) begin
			if (pwrite) begin
				case (paddr)
					acrc_pkg::REG_CTRL: begin
						next_q.ctrl = pwdata[4:0];
						next_q.rate = pwdata[acrc_pkg::CTRL_RATE_LSB +: 3];
					end
					acrc_pkg::REG_GPIO: begin
						next_q.gout = pwdata[3:0];
						next_q.goe_n = ~pwdata[7:4];
					end
					acrc_pkg::REG_STATUS: begin
						st_clr = pwdata[2:0];
					end
					acrc_pkg::REG_MASK: begin
						next_q.mask = pwdata[2:0];
					end
					acrc_pkg::REG_CONV: begin
						start = pwdata[0];
					end
					acrc_pkg::REG_DATA: begin
						// Read-only, write ignored
					end
					default: begin
						next_q.pslverr = 1'b1;
					end
				endcase
			end else begin
				case (paddr)
					acrc_pkg::REG_CTRL: begin
						next_q.prdata = {21'h0, q.rate, 3'h0, q.ctrl};
					end
					acrc_pkg::REG_GPIO: begin
						next_q.prdata = {20'h0, q.gin_b, ~q.goe_n, q.gout};
					end
					acrc_pkg::REG_DATA: begin
						// Reading the result consumes it
						next_q.prdata = {8'h0, q.result};
						next_q.ready = 1'b0;
					end
					acrc_pkg::REG_STATUS: begin
						next_q.prdata = {29'h0, q.status};
					end
					acrc_pkg::REG_MASK: begin
						next_q.prdata = {29'h0, q.mask};
					end
					acrc_pkg::REG_CONV: begin
						next_q.prdata = {30'h0, q.ready, q.run};
					end
					default: begin
						next_q.prdata = 32'h0;
						next_q.pslverr = 1'b1;
					end
				endcase
			end
		end

		// Serial engine; all of it idles while chip select is high
		next_q.dout_oe_n = q.cs_s[1];
		if (!sel) begin
			next_q.ser_state = acrc_pkg::ACRC_SER_CMD;
			next_q.bit_cnt = 5'h0;
			if (frame_end) begin
				st_set[acrc_pkg::ST_FRAME_BIT] = 1'b1;
			end
		end else begin
			if (sclk_rise) begin
				next_q.sin = rx_byte;
				next_q.bit_cnt = 5'(q.bit_cnt + 5'h1);
				case (q.ser_state)
					acrc_pkg::ACRC_SER_CMD: begin
						if (q.bit_cnt == acrc_pkg::SER_BYTE_LAST) begin
							next_q.bit_cnt = 5'h0;
							if (rx_byte[acrc_pkg::CMD_CONV_BIT]) begin
								// Conversion command carries the rate code
								start = 1'b1;
								start_rate = rx_byte[2:0];
								next_q.ser_state = acrc_pkg::ACRC_SER_DONE;
							end else if (rx_byte[6:5] == acrc_pkg::CMD_READ) begin
								next_q.sout = q.result;
								next_q.ser_state = acrc_pkg::ACRC_SER_READ;
							end else begin
								next_q.wr_gpio = rx_byte[acrc_pkg::CMD_GPIO_BIT];
								next_q.ser_state = acrc_pkg::ACRC_SER_WRITE;
							end
						end
					end
					acrc_pkg::ACRC_SER_WRITE: begin
						if (q.bit_cnt == acrc_pkg::SER_BYTE_LAST) begin
							if (q.wr_gpio) begin
								next_q.gout = rx_byte[3:0];
								next_q.goe_n = ~rx_byte[7:4];
							end else begin
								next_q.ctrl = rx_byte[4:0];
							end
							next_q.ser_state = acrc_pkg::ACRC_SER_DONE;
						end
					end
					acrc_pkg::ACRC_SER_READ: begin
						if (q.bit_cnt == acrc_pkg::SER_READ_LAST) begin
							next_q.ready = 1'b0;
							next_q.ser_state = acrc_pkg::ACRC_SER_DONE;
						end
					end
					acrc_pkg::ACRC_SER_DONE: begin
						// Extra clocks ignored until deselect
						next_q.bit_cnt = q.bit_cnt;
					end
					default: begin
						next_q.ser_state = acrc_pkg::ACRC_SER_CMD;
					end
				endcase
			end
			// Output moves on the falling edge so the host samples on the rise
			if (sclk_fall) begin
				if (q.ser_state == acrc_pkg::ACRC_SER_READ) begin
					next_q.dout = q.sout[23];
					next_q.sout = {q.sout[22:0], 1'b0};
				end else begin
					next_q.dout = ~q.ready;
				end
			end
		end

		// System clock: oscillator model or the external pin
		nco_sum = {1'b0, q.phase} + {1'b0, q.ctrl[acrc_pkg::CTRL_LINE_BIT] ?
			acrc_pkg::NCO_INC_LO : acrc_pkg::NCO_INC_HI};
		next_q.phase = nco_sum[23:0];
		// An external frequency below half the pclk rate simply scales every later count
		if (q.ctrl[acrc_pkg::CTRL_EXT_BIT]) begin
			sys_tick = q.ext_s[1] & ~q.ext_s[2];
		end else begin
			sys_tick = nco_sum[24];
		end

		// Sampling divider, one sample per ten system clocks
		sample_tick = 1'b0;
		if (sys_tick) begin
			if (q.div == acrc_pkg::SAMPLE_DIV_LAST) begin
				next_q.div = 4'h0;
				sample_tick = 1'b1;
			end else begin
				next_q.div = 4'(q.div + 4'h1);
			end
		end
		next_q.strobe = sample_tick;

		// Conversion timing in sampling periods
		if (start) begin
			next_q.rate = start_rate;
			next_q.run = 1'b1;
			next_q.samples = 18'h0;
		end else if (q.run && sample_tick) begin
			if (q.samples == 18'(conv_samples(q.ctrl[acrc_pkg::CTRL_SCYC_BIT],
				q.rate) - 18'h1)) begin
				next_q.samples = 18'h0;
				next_q.result = conv_data;
				next_q.ready = 1'b1;
				st_set[acrc_pkg::ST_DONE_BIT] = 1'b1;
				st_set[acrc_pkg::ST_OVERRUN_BIT] = q.ready;
				// Single-cycle stops after one result
				if (q.ctrl[acrc_pkg::CTRL_SCYC_BIT]) begin
					next_q.run = 1'b0;
				end
			end else begin
				next_q.samples = 18'(q.samples + 18'h1);
			end
		end

		// Sticky status; a new event beats a clear in the same cycle
		next_q.status = (q.status & ~st_clr) | st_set;
		next_q.irq = |(next_q.status & next_q.mask);
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.cs_s <= 3'h7;
			q.sclk_s <= 3'h0;
			q.ctrl <= acrc_pkg::CTRL_RESET;
			q.rate <= acrc_pkg::RATE_RESET;
			q.goe_n <= acrc_pkg::GPIO_OE_N_RESET;
			q.ser_state <= acrc_pkg::ACRC_SER_CMD;
			q.dout <= 1'b1;
			q.dout_oe_n <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// Outputs, each straight from a state flop
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign dout = q.dout;
	assign dout_oe_n = q.dout_oe_n;
	assign general_pin_one_out = q.gout[0];
	assign general_pin_two_out = q.gout[1];
	assign general_pin_three_out = q.gout[2];
	assign general_pin_four_out = q.gout[3];
	assign general_pin_one_oe_n = q.goe_n[0];
	assign general_pin_two_oe_n = q.goe_n[1];
	assign general_pin_three_oe_n = q.goe_n[2];
	assign general_pin_four_oe_n = q.goe_n[3];
	assign sample_strobe = q.strobe;
	assign external_clock_select = q.ctrl[acrc_pkg::CTRL_EXT_BIT];
	assign line_frequency_select = q.ctrl[acrc_pkg::CTRL_LINE_BIT];
	assign signal_buffer_enable = q.ctrl[acrc_pkg::CTRL_BUF_BIT];
	assign unipolar_select = q.ctrl[acrc_pkg::CTRL_UNI_BIT];
	assign single_cycle_select = q.ctrl[acrc_pkg::CTRL_SCYC_BIT];
	assign irq = q.irq;

endmodule

// ### acrc_top_tb.sv
// Self-checking bench: APB master, serial host model, pin loopback.
// Assumes a 10 MHz pclk; continuous code 111 and single-cycle code 111.
`timescale 1ns/100ps
module acrc_top_tb;
	logic        pclk      = 1'b0;
	logic        presetn   = 1'b0;
	logic        ext_clk   = 1'b0;
	logic [11:0] paddr     = 12'h000;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [31:0] pwdata    = 32'h0000_0000;
	logic [23:0] conv_data = 24'h5a3c96; // Fixed result word
	logic [3:0]  ext_pin   = 4'ha;       // Far level on undriven pins
	logic [31:0] prdata, r;
	logic        pready, pslverr, e, dout, dout_oe_n, sample_strobe, irq;
	logic        external_clock_select, line_frequency_select, signal_buffer_enable;
	logic        unipolar_select, single_cycle_select;
	logic [3:0]  po, poe;
	wire logic   cs_n, sclk, din;
	wire [3:0]   pin;
	int          mismatches  = 0;
	int          checks_done = 0;

	// Pin level: device drives when enable low, else far side
	assign pin = (poe & ext_pin) | (~poe & po);
	always #50 pclk = ~pclk;
	// 2 MHz, offset so no pin edge lands on a pclk edge; rates scale
	initial #20 forever #250 ext_clk = ~ext_clk;

	acrc_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .cs_n, .sclk, .din, .dout, .dout_oe_n, .ext_clk,
		.general_pin_one_in(pin[0]), .general_pin_two_in(pin[1]),
		.general_pin_three_in(pin[2]), .general_pin_four_in(pin[3]),
		.general_pin_one_out(po[0]), .general_pin_two_out(po[1]),
		.general_pin_three_out(po[2]), .general_pin_four_out(po[3]),
		.general_pin_one_oe_n(poe[0]), .general_pin_two_oe_n(poe[1]),
		.general_pin_three_oe_n(poe[2]), .general_pin_four_oe_n(poe[3]),
		.conv_data, .sample_strobe, .external_clock_select, .line_frequency_select,
		.signal_buffer_enable, .unipolar_select, .single_cycle_select, .irq);
	acrc_host_model host (.cs_n, .sclk, .din, .dout, .dout_oe_n);

	// Value compare
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Count compare within a window
	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		checks_done++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	// One APB transfer; result lands in r and e
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		chk_rng("pready wait", 1, 49, n);
	endtask
	// Wait for the interrupt, bounded
	task automatic wait_irq(output int n);
		n = 0;
		for (int i = 0; i < 40000 && irq !== 1'b1; i++) begin
			@(posedge pclk);
			if (sample_strobe === 1'b1) n++;
		end
		chk("irq raised", 32'h1, {31'h0, irq});
	endtask

	// Reset values, refusal, control and pin registers
	task automatic t_regs;
		apb(1'b0, acrc_pkg::REG_CTRL, 32'h0);
		chk("ctrl reset", 32'h0000_0400, r);
		apb(1'b0, acrc_pkg::REG_GPIO, 32'h0);
		chk("gpio reset", 32'h0000_0a00, r);
		apb(1'b0, 12'h018, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, e});
		apb(1'b1, acrc_pkg::REG_CTRL, 32'h0000_071f);
		apb(1'b0, acrc_pkg::REG_CTRL, 32'h0);
		chk("ctrl back", 32'h0000_071f, r);
		chk("selects", 32'h1f, {27'h0, single_cycle_select, unipolar_select,
			signal_buffer_enable, line_frequency_select, external_clock_select});
		apb(1'b1, acrc_pkg::REG_GPIO, 32'h0000_00c5);
		apb(1'b0, acrc_pkg::REG_GPIO, 32'h0);
		chk("gpio back", 32'h0000_06c5, r);
		chk("pin enables", 32'h3, {28'h0, poe});
	endtask

	// Continuous code 111: samples per result, interrupt path
	task automatic t_conv;
		int n;
		apb(1'b1, acrc_pkg::REG_CTRL, 32'h0000_0700);
		apb(1'b1, acrc_pkg::REG_MASK, 32'h1);
		apb(1'b1, acrc_pkg::REG_CONV, 32'h1);
		wait_irq(n);
		chk_rng("samples per result", 511, 513, n);
		apb(1'b0, acrc_pkg::REG_STATUS, 32'h0);
		chk("done flag", 32'h1, r & 32'h1);
		apb(1'b0, acrc_pkg::REG_DATA, 32'h0);
		chk("result", 32'h005a_3c96, r);
		apb(1'b1, acrc_pkg::REG_MASK, 32'h0);
		repeat (3) @(posedge pclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, acrc_pkg::REG_MASK, 32'h1);
		repeat (3) @(posedge pclk);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		apb(1'b1, acrc_pkg::REG_STATUS, 32'h7);
		repeat (3) @(posedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
	endtask

	// Single-cycle code 111 runs on past the continuous count
	task automatic t_single;
		int n;
		apb(1'b1, acrc_pkg::REG_CTRL, 32'h0000_0710);
		apb(1'b1, acrc_pkg::REG_CONV, 32'h1);
		n = 0;
		for (int i = 0; i < 30000 && n < 600; i++) begin
			@(posedge pclk);
			if (sample_strobe === 1'b1) n++;
		end
		chk("single samples", 32'h0000_0258, n);
		apb(1'b0, acrc_pkg::REG_CONV, 32'h0);
		chk("single still running", 32'h1, r & 32'h1);
		apb(1'b0, acrc_pkg::REG_STATUS, 32'h0);
		chk("single no result yet", 32'h0, r & 32'h1);
	endtask

	// Sample rate per clock source over 4000 cycles
	task automatic t_rates;
		logic [31:0] cfg [3] = '{32'h0000_0700, 32'h0000_0702, 32'h0000_0701};
		int          lo [3]  = '{98, 81, 79};
		int          n;
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, acrc_pkg::REG_CTRL, cfg[k]);
			apb(1'b1, acrc_pkg::REG_CONV, 32'h1);
			n = 0;
			repeat (4000) begin
				@(posedge pclk);
				if (sample_strobe === 1'b1) n++;
			end
			chk_rng("sample rate", lo[k], lo[k] + 2, n);
		end
	endtask

	// Serial read, pin and control writes, ready on the shared line
	task automatic t_serial;
		logic [31:0] rx;
		int          n;
		apb(1'b1, acrc_pkg::REG_STATUS, 32'h7);
		wait_irq(n);
		host.frame(32, 32'h6000_0000, rx);
		chk("ready in frame", 32'h0, rx >> 24);
		chk("serial result", 32'h005a_3c96, rx & 32'h00ff_ffff);
		host.frame(16, 32'h0000_40f9, rx);
		chk("not ready in frame", 32'h0000_ffff, rx);
		chk("serial pins", 32'h9, {28'h0, po});
		chk("serial enables", 32'h0, {28'h0, poe});
		host.frame(16, 32'h0000_001a, rx);
		chk("serial selects", 32'h1a, {27'h0, single_cycle_select, unipolar_select,
			signal_buffer_enable, line_frequency_select, external_clock_select});
		apb(1'b0, acrc_pkg::REG_STATUS, 32'h0);
		chk("frame end flag", 32'h2, r & 32'h2);
	endtask

	// Verdict and end of run
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence after three reset cycles
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_conv;
		t_single;
		t_rates;
		t_serial;
		wrap_up;
	end

	// Watchdog past the expected 80k cycles
	initial begin
		#9_000_000;
		mismatches++;
		wrap_up;
	end
endmodule

bind acrc_top acrc_checker chk_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
	.pwdata, .pready, .pslverr, .cs_n, .sclk, .dout, .dout_oe_n, .sample_strobe,
	.external_clock_select, .line_frequency_select, .signal_buffer_enable,
	.unipolar_select, .single_cycle_select, .irq);
